// ==== hdl/fic_pkg.sv ====
/*
 * constants, field positions and carrier types for the four-level interrupt controller.
 * assumes an 8-bit special-function-register port from the cpu core, same clock.
 */
package fic_pkg;
    localparam int NUM_SRC = 15;
    localparam int LEVEL_W = 2;
    localparam int NUM_LEVELS = 4;
    // register addresses on the special-function-register port
    localparam logic [7:0] ADDR_SOURCE_ENABLE_A = 8'hA8;
    localparam logic [7:0] ADDR_PRIORITY_HIGH_A = 8'hB7;
    localparam logic [7:0] ADDR_PRIORITY_LOW_A = 8'hB8;
    localparam logic [7:0] ADDR_SOURCE_ENABLE_B = 8'hE8;
    localparam logic [7:0] ADDR_PRIORITY_HIGH_B = 8'hF7;
    localparam logic [7:0] ADDR_PRIORITY_LOW_B = 8'hF8;
    // timer flag byte: capture 0..3, compare 0..1, byte overflow, full overflow
    localparam logic [7:0] ADDR_TIMER_FLAGS = 8'hC0;
    localparam logic [7:0] ADDR_MISC_FLAGS = 8'hC1;
    localparam logic [7:0] ADDR_IN_SERVICE = 8'hC2;
    localparam int TF_CAPTURE = 0;
    localparam int TF_COMPARE = 4;
    localparam int TF_BYTE_OVF = 6;
    localparam int TF_FULL_OVF = 7;
    // misc flag byte fields
    localparam int MF_EXT_A = 0;
    localparam int MF_TIMER_A = 1;
    localparam int MF_EXT_B = 2;
    localparam int MF_TIMER_B = 3;
    localparam int MF_UART = 4;
    localparam int MF_TWOWIRE = 5;
    localparam int MF_ADC = 6;
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESERVED_MASK_A = 8'h7F;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_SHIFT = 3;
    // source index = vector slot; polling rank per slot (0 = polled first)
    localparam logic [3:0] POLL_RANK [NUM_SRC] = '{
        4'h0, 4'h3, 4'h6, 4'h9, 4'hC, 4'h1, 4'h4, 4'h7,
        4'hA, 4'hD, 4'h2, 4'h5, 4'h8, 4'hB, 4'hE};

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
    } fic_sfr_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] level;
        logic [3:0] source;
        logic [15:0] vector;
    } fic_irq_req_t;
endpackage

// ==== hdl/fic_controller.sv ====
/*
 * fifteen-source, four-level interrupt controller with flag bank, enables,
 * priorities, fixed polling order and an in-service level stack.
 * assumes the cpu core drives the register port and ack/return strobes on clk.
 */
`timescale 1ns/1ns
module fic_controller
(
    input wire logic clk, // 25 MHz system clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire fic_pkg::fic_sfr_req_t sfrReq, // register write/address from core
    output logic [7:0] sfrRdata, // read data for sfrReq.addr
    input wire logic extIrqPinA, // external request a, level
    input wire logic extIrqPinB, // external request b, level
    input wire logic [3:0] captureIrqPins, // capture inputs, rising edge
    input wire logic timerAOverflow, // timer a overflow pulse
    input wire logic timerBOverflow, // timer b overflow pulse
    input wire logic uartIrq, // uart request level
    input wire logic twowireStatusLoad, // two-wire status loaded with valid code
    input wire logic conversionDone, // adc result ready pulse
    input wire logic [7:0] canIrqStatus, // can interrupt status byte
    input wire logic [15:0] ccTimerValue, // cc timer count
    input wire logic [15:0] compareValueA, // compare register a
    input wire logic [15:0] compareValueB, // compare register b
    input wire logic byteOverflow, // cc timer 8-bit overflow pulse
    input wire logic fullOverflow, // cc timer 16-bit overflow pulse
    input wire logic irqAck, // core takes the offered request
    input wire logic irqReturn, // core finishes current service routine
    output fic_pkg::fic_irq_req_t irqReq // request offered to the core
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers

logic [7:0] pinMeta_reg;
logic [7:0] pinSync_reg;
logic [3:0] capturePrev_reg;
logic [15:0] ccPrev_reg;

// pin levels pass two flops before any logic sees them; capture edges are
// found one flop later, so a capture flag trails its pin by three cycles

always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        pinMeta_reg <= fic_pkg::RESET_BYTE;
        pinSync_reg <= fic_pkg::RESET_BYTE;
    end
    else
    begin
        pinMeta_reg <= {2'b00, captureIrqPins, extIrqPinB, extIrqPinA};
        pinSync_reg <= pinMeta_reg;
    end
end

always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        capturePrev_reg <= 4'h0;
        ccPrev_reg <= 16'h0000;
    end
    else
    begin
        capturePrev_reg <= pinSync_reg[5:2];
        ccPrev_reg <= ccTimerValue;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register file

logic [7:0] enableA_reg;
logic [7:0] enableB_reg;
logic [7:0] prioHighA_reg;
logic [7:0] prioLowA_reg;
logic [7:0] prioHighB_reg;
logic [7:0] prioLowB_reg;

function automatic logic wr(input fic_pkg::fic_sfr_req_t r, input logic [7:0] a);
    return r.write && (r.addr == a);
endfunction

always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        enableA_reg <= fic_pkg::RESET_BYTE;
        enableB_reg <= fic_pkg::RESET_BYTE;
        prioHighA_reg <= fic_pkg::RESET_BYTE;
        prioLowA_reg <= fic_pkg::RESET_BYTE;
        prioHighB_reg <= fic_pkg::RESET_BYTE;
        prioLowB_reg <= fic_pkg::RESET_BYTE;
    end
    else
    begin
        // bit 7 of enable a is the global gate and reads back as written
        if (wr(sfrReq, fic_pkg::ADDR_SOURCE_ENABLE_A))
            enableA_reg <= sfrReq.wdata;
        if (wr(sfrReq, fic_pkg::ADDR_SOURCE_ENABLE_B))
            enableB_reg <= sfrReq.wdata;
        // bit 7 of the a-side priority pair is reserved and holds zero
        if (wr(sfrReq, fic_pkg::ADDR_PRIORITY_HIGH_A))
            prioHighA_reg <= sfrReq.wdata & fic_pkg::RESERVED_MASK_A;
        if (wr(sfrReq, fic_pkg::ADDR_PRIORITY_LOW_A))
            prioLowA_reg <= sfrReq.wdata & fic_pkg::RESERVED_MASK_A;
        if (wr(sfrReq, fic_pkg::ADDR_PRIORITY_HIGH_B))
            prioHighB_reg <= sfrReq.wdata;
        if (wr(sfrReq, fic_pkg::ADDR_PRIORITY_LOW_B))
            prioLowB_reg <= sfrReq.wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// request flags

logic [7:0] timerFlags_reg;
logic [7:0] timerFlags_next;
logic [6:0] miscFlags_reg;
logic [6:0] miscFlags_next;
logic [7:0] timerEvents;
logic [6:0] miscEvents;
logic [7:0] inService_reg;

always_comb
begin
    timerEvents = 8'h00;
    timerEvents[fic_pkg::TF_CAPTURE +: 4] = pinSync_reg[5:2] & ~capturePrev_reg;
    // compare fires once on the cycle the timer arrives at the value
    timerEvents[fic_pkg::TF_COMPARE] = (ccTimerValue == compareValueA)
        && (ccPrev_reg != compareValueA);
    timerEvents[fic_pkg::TF_COMPARE + 1] = (ccTimerValue == compareValueB)
        && (ccPrev_reg != compareValueB);
    timerEvents[fic_pkg::TF_BYTE_OVF] = byteOverflow;
    timerEvents[fic_pkg::TF_FULL_OVF] = fullOverflow;
    // external pins act as levels: the flag is set again every cycle a pin is high
    miscEvents = 7'h00;
    miscEvents[fic_pkg::MF_EXT_A] = pinSync_reg[0];
    miscEvents[fic_pkg::MF_TIMER_A] = timerAOverflow;
    miscEvents[fic_pkg::MF_EXT_B] = pinSync_reg[1];
    miscEvents[fic_pkg::MF_TIMER_B] = timerBOverflow;
    miscEvents[fic_pkg::MF_UART] = uartIrq;
    miscEvents[fic_pkg::MF_TWOWIRE] = twowireStatusLoad;
    miscEvents[fic_pkg::MF_ADC] = conversionDone;
    timerFlags_next = timerFlags_reg;
    if (wr(sfrReq, fic_pkg::ADDR_TIMER_FLAGS))
        timerFlags_next = sfrReq.wdata;
    // hardware only sets; a set in the clearing cycle wins
    timerFlags_next = timerFlags_next | timerEvents;
    miscFlags_next = miscFlags_reg;
    if (wr(sfrReq, fic_pkg::ADDR_MISC_FLAGS))
    begin
        miscFlags_next = sfrReq.wdata[6:0];
        // the adc flag can only be lowered by a write
        miscFlags_next[fic_pkg::MF_ADC] = miscFlags_reg[fic_pkg::MF_ADC]
            & sfrReq.wdata[fic_pkg::MF_ADC];
    end
    miscFlags_next = miscFlags_next | miscEvents;
end

always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        timerFlags_reg <= fic_pkg::RESET_BYTE;
        miscFlags_reg <= 7'h00;
    end
    else
    begin
        timerFlags_reg <= timerFlags_next;
        miscFlags_reg <= miscFlags_next;
    end
end

always_comb
begin
    // combinational read: a write shows up here on the cycle after it is taken
    unique case (sfrReq.addr)
        fic_pkg::ADDR_SOURCE_ENABLE_A: sfrRdata = enableA_reg;
        fic_pkg::ADDR_SOURCE_ENABLE_B: sfrRdata = enableB_reg;
        fic_pkg::ADDR_PRIORITY_HIGH_A: sfrRdata = prioHighA_reg;
        fic_pkg::ADDR_PRIORITY_LOW_A: sfrRdata = prioLowA_reg;
        fic_pkg::ADDR_PRIORITY_HIGH_B: sfrRdata = prioHighB_reg;
        fic_pkg::ADDR_PRIORITY_LOW_B: sfrRdata = prioLowB_reg;
        fic_pkg::ADDR_TIMER_FLAGS: sfrRdata = timerFlags_reg;
        fic_pkg::ADDR_MISC_FLAGS: sfrRdata = {1'b0, miscFlags_reg};
        fic_pkg::ADDR_IN_SERVICE: sfrRdata = inService_reg;
        default: sfrRdata = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// source map, in vector-slot order

logic [fic_pkg::NUM_SRC-1:0] srcPending;
logic [fic_pkg::NUM_SRC-1:0] srcEnable;
logic [fic_pkg::NUM_SRC-1:0] srcHigh;
logic [fic_pkg::NUM_SRC-1:0] srcLow;

always_comb
begin
    // flags are read as levels so an unserviced flag re-requests
    // the overflow slot ors both overflow flags; software must clear both
    srcPending = {
        timerFlags_reg[fic_pkg::TF_FULL_OVF] | timerFlags_reg[fic_pkg::TF_BYTE_OVF],
        |canIrqStatus,
        timerFlags_reg[fic_pkg::TF_COMPARE +: 2],
        miscFlags_reg[fic_pkg::MF_ADC],
        timerFlags_reg[fic_pkg::TF_CAPTURE +: 4],
        miscFlags_reg[fic_pkg::MF_TWOWIRE],
        miscFlags_reg[fic_pkg::MF_UART],
        miscFlags_reg[fic_pkg::MF_TIMER_B],
        miscFlags_reg[fic_pkg::MF_EXT_B],
        miscFlags_reg[fic_pkg::MF_TIMER_A],
        miscFlags_reg[fic_pkg::MF_EXT_A]};
    srcEnable = {enableB_reg[7:4], enableA_reg[6], enableB_reg[3:0], enableA_reg[5:0]};
    srcHigh = {prioHighB_reg[7:4], prioHighA_reg[6], prioHighB_reg[3:0], prioHighA_reg[5:0]};
    srcLow = {prioLowB_reg[7:4], prioLowA_reg[6], prioLowB_reg[3:0], prioLowA_reg[5:0]};
end

////////////////////////////////////////////////////////////////////////////////
// arbitration and in-service stack

// one bit per level; the highest set bit is the routine running now
logic [fic_pkg::NUM_LEVELS-1:0] levelActive_reg;
logic [3:0] winSrc;
logic [1:0] winLevel;
logic winValid;
logic [2:0] activeTop;

// one above the highest busy level, so an idle stack compares as zero
function automatic logic [2:0] topLevel(input logic [3:0] act);
    logic [2:0] t;
    t = 3'd0;
    for (int i = 0; i < 4; i++)
        if (act[i])
            t = 3'(i + 1);
    return t;
endfunction

always_comb
begin
    logic [1:0] lvl;
    logic [3:0] bestRank;
    lvl = 2'd0;
    bestRank = 4'hF;
    winSrc = 4'h0;
    winLevel = 2'd0;
    winValid = 1'b0;
    activeTop = topLevel(levelActive_reg);
    // a level must sit above the stack top, so an equal level waits its turn
    for (int s = 0; s < fic_pkg::NUM_SRC; s++)
    begin
        lvl = {srcHigh[s], srcLow[s]};
        if (srcPending[s] && srcEnable[s]
            && enableA_reg[fic_pkg::GLOBAL_ENABLE_BIT]
            && ({1'b0, lvl} >= activeTop))
        begin
            // ties at one level go to the lower polling rank
            if (!winValid || lvl > winLevel
                || (lvl == winLevel && fic_pkg::POLL_RANK[s] < bestRank))
            begin
                winValid = 1'b1;
                winLevel = lvl;
                winSrc = 4'(s);
                bestRank = fic_pkg::POLL_RANK[s];
            end
        end
    end
end

logic [fic_pkg::NUM_LEVELS-1:0] levelActive_next;

always_comb
begin
    levelActive_next = levelActive_reg;
    // return retires only the routine on top; the preempted one resumes
    if (irqReturn && activeTop != 3'd0)
        levelActive_next[activeTop[1:0] - 2'd1] = 1'b0;
    // a take in the same cycle lands above the retired level, never on it
    if (irqAck && irqReq.valid)
        levelActive_next[irqReq.level] = 1'b1;
end

always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        levelActive_reg <= 4'h0;
    else
        levelActive_reg <= levelActive_next;
end

// software sees the stack one cycle late through the in-service byte
always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        inService_reg <= fic_pkg::RESET_BYTE;
    else
        inService_reg <= {4'h0, levelActive_reg};
end

// offer stands while the winner is valid; it is dropped for the cycle after it is accepted
// the offer trails the flags by a cycle, so a just-cleared flag can still be taken
always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
        irqReq <= '0;
    else
    begin
        irqReq.valid <= winValid && !(irqAck && irqReq.valid);
        irqReq.level <= winLevel;
        irqReq.source <= winSrc;
        irqReq.vector <= fic_pkg::VECTOR_BASE
            + (16'(winSrc) << fic_pkg::VECTOR_SHIFT);
    end
end

endmodule

// ==== bench/fic_props.sv ====
/* checker bound to the controller: offers, nesting and register reads.
   assumes one clock and the fic_pkg carriers on the controller ports. */
`timescale 1ns/1ns
module fic_props
(
    input wire logic clk, // clock
    input wire logic rst_n, // async reset
    input wire fic_pkg::fic_sfr_req_t sfrReq, // register port
    input wire logic [7:0] sfrRdata, // read data
    input wire logic conversionDone, // adc set pulse
    input wire logic irqAck, // core takes offer
    input wire logic irqReturn, // core ends routine
    input wire fic_pkg::fic_irq_req_t irqReq // offer
);
    logic [3:0] inSvc;
    logic [2:0] top;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // top is one above the highest level in service, zero when idle
    assign top = inSvc[3] ? 3'h4 : inSvc[2] ? 3'h3 : inSvc[1] ? 3'h2 : {2'h0, inSvc[0]};
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            inSvc <= 4'h0;
        else
        begin
            // a return and a take may share a cycle; the take lands above
            if (irqReturn && top != 3'h0)
                inSvc[top[1:0] - 2'h1] <= 1'b0;
            if (irqAck && irqReq.valid)
                inSvc[irqReq.level] <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////
    chk_vector_map: assert property (irqReq.valid |->
        irqReq.vector == 16'h0003 + {9'h000, irqReq.source, 3'h0})
        else $error("vector does not follow source");
    chk_source_range: assert property (irqReq.valid |-> irqReq.source <= 4'hE)
        else $error("source out of range");
    chk_ack_drop: assert property (irqAck && irqReq.valid |=> !irqReq.valid)
        else $error("offer stands after being taken");
    chk_nest_level: assert property (irqReq.valid |-> {1'b0, irqReq.level} >= top)
        else $error("offer not above level in service");
    chk_global_gate: assert property (sfrReq.write && sfrReq.addr == 8'hA8
        && !sfrReq.wdata[7] |=> ##1 !irqReq.valid)
        else $error("offer while globally disabled");
    chk_reserved_bit: assert property ((sfrReq.addr == 8'hB7 || sfrReq.addr == 8'hB8)
        |-> !sfrRdata[7])
        else $error("reserved priority bit reads set");
    chk_adc_no_set: assert property (sfrReq.write && sfrReq.addr == 8'hC1 && sfrReq.wdata[6]
        && !sfrRdata[6] && !conversionDone |=> sfrReq.addr != 8'hC1 || !sfrRdata[6])
        else $error("software set the adc flag");
    chk_reset_clear: assert property ($rose(rst_n) |-> irqReq == '0)
        else $error("offer not clear after reset");
    cov_top_level: cover property (irqAck && irqReq.valid && irqReq.level == 2'h3);
    cov_nested: cover property (inSvc[3] && inSvc[1]);
    cov_can_taken: cover property (irqAck && irqReq.valid && irqReq.source == 4'hD);
endmodule
bind fic_controller fic_props fic_props_inst (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq),
    .sfrRdata(sfrRdata), .conversionDone(conversionDone), .irqAck(irqAck),
    .irqReturn(irqReturn), .irqReq(irqReq));

// ==== bench/fic_core_model.sv ====
/* cpu-core side: takes offered requests after a lag and ends routines.
   assumes the bench steers take, lag and finish on clk. */
`timescale 1ns/1ns
module fic_core_model
(
    input wire logic clk, // clock
    input wire logic rst_n, // async reset
    input wire fic_pkg::fic_irq_req_t irqReq, // offer
    input wire logic take, // allow taking
    input wire logic [1:0] lag, // cycles to wait before taking
    input wire logic finish, // end one routine
    output logic irqAck, // take strobe
    output logic irqReturn // return strobe
);
    logic [1:0] waitCnt;
    logic [3:0] depth;
    // never returns with nothing taken, so nesting stays paired
    assign irqReturn = finish && depth != 4'h0;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irqAck <= 1'b0;
            waitCnt <= 2'h0;
        end
        else
        begin
            irqAck <= 1'b0;
            if (!irqReq.valid || !take || irqAck)
                waitCnt <= 2'h0;
            else if (waitCnt >= lag)
                irqAck <= 1'b1;
            else
                waitCnt <= waitCnt + 2'h1;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            depth <= 4'h0;
        else
            depth <= depth + {3'h0, irqAck && irqReq.valid} - {3'h0, irqReturn};
    end
endmodule

// ==== bench/fic_controller_bench.sv ====
/* self-checking bench for the interrupt controller.
   assumes fic_core_model as the core and fic_props bound to the controller. */
`timescale 1ns/1ns
module fic_controller_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    fic_pkg::fic_sfr_req_t sfrReq = '0;
    logic [7:0] sfrRdata;
    logic [15:0] hw = 16'h0000;
    logic [7:0] canStat = 8'h00;
    logic take = 1'b1;
    logic [1:0] lag = 2'h0;
    logic finish = 1'b0;
    logic irqAck;
    logic irqReturn;
    fic_pkg::fic_irq_req_t irqReq;
    fic_pkg::fic_irq_req_t notes[$];
    int fails = 0;
    int num_checks = 0;
    int acks = 0;
    logic [31:0] rng = 32'h00006B54;
    logic [7:0] timF = 8'hFF;
    logic [7:0] misF = 8'h7F;
    logic [3:0] s;
    logic [7:0] regs [6] = '{8'hA8, 8'hB7, 8'hB8, 8'hE8, 8'hF7, 8'hF8};
    logic [3:0] poll [15] = '{4'h0, 4'h5, 4'hA, 4'h1, 4'h6, 4'hB, 4'h2, 4'h7,
        4'hC, 4'h3, 4'h8, 4'hD, 4'h4, 4'h9, 4'hE};
    always #20 clk = ~clk;
    fic_controller fic_controller_inst (.clk(clk), .rst_n(rst_n), .sfrReq(sfrReq),
        .sfrRdata(sfrRdata), .extIrqPinA(hw[0]), .timerAOverflow(hw[1]),
        .extIrqPinB(hw[2]), .timerBOverflow(hw[3]), .uartIrq(hw[4]),
        .twowireStatusLoad(hw[5]), .captureIrqPins(hw[9:6]), .conversionDone(hw[10]),
        .ccTimerValue(hw[11] ? 16'h1111 : hw[12] ? 16'h2222 : 16'h0000),
        .compareValueA(16'h1111), .compareValueB(16'h2222),
        .canIrqStatus(hw[13] ? canStat : 8'h00), .byteOverflow(hw[14]),
        .fullOverflow(hw[15]), .irqAck(irqAck), .irqReturn(irqReturn), .irqReq(irqReq));
    fic_core_model fic_core_model_inst (.clk(clk), .rst_n(rst_n), .irqReq(irqReq),
        .take(take), .lag(lag), .finish(finish), .irqAck(irqAck), .irqReturn(irqReturn));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrReq = '{a, d, 1'b1};
        tick(1);
        sfrReq.write = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a);
        sfrReq.addr = a;
        tick(1);
    endtask
    task automatic note(input logic [3:0] src, input logic [1:0] l);
        notes.push_back('{1'b1, l, src, 16'h0003 + {9'h000, src, 3'h0}});
    endtask
    // a quiet wait (want 0) spans the full window, so late offers still show
    task automatic wack(input int want);
        int n;
        n = acks;
        repeat (30)
            if (acks == n)
                tick(1);
        chk(23'(acks - n), 23'(want));
    endtask
    task automatic ret();
        finish = 1'b1;
        tick(1);
        finish = 1'b0;
    endtask
    task automatic test_done();
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk)
        if (irqAck && irqReq.valid)
        begin
            acks++;
            if (notes.size() == 0)
                chk(irqReq, '0);
            else
                chk(irqReq, notes.pop_front());
        end
    initial
    begin
        #2000000;
        fails++;
        test_done();
    end
    initial
    begin
        tick(3);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            rd(regs[i]);
            chk(23'(sfrRdata), 23'h0);
            rng = xs(rng);
            wr(regs[i], rng[7:0]);
            rd(regs[i]);
            chk(23'(sfrRdata), 23'(rng[7:0] & ((i == 1 || i == 2) ? 8'h7F : 8'hFF)));
        end
        rd(8'h55);
        chk(23'(sfrRdata), 23'h0);
        for (int i = 0; i < 6; i++)
            wr(regs[i], (i == 0) ? 8'h7F : (i == 3) ? 8'hFF : 8'h00);
        $display("test registers done");
        wr(8'hC1, 8'h01);
        wack(0);
        wr(8'hA8, 8'hFE);
        wack(0);
        lag = 2'h2;
        note(4'h0, 2'h0);
        wr(8'hA8, 8'hFF);
        wack(1);
        wr(8'hC1, 8'h40);
        rd(8'hC1);
        chk(23'(sfrRdata), 23'h0);
        ret();
        note(4'hB, 2'h0);
        note(4'hB, 2'h0);
        wr(8'hC0, 8'h10);
        wack(1);
        rd(8'hC0);
        chk(23'(sfrRdata), 23'h10);
        ret();
        wack(1);
        wr(8'hC0, 8'h00);
        ret();
        $display("test enables done");
        for (int k = 0; k < 16; k++)
        begin
            rng = xs(rng);
            canStat = rng[7:0] | 8'h01;
            lag = rng[9:8];
            note(4'(k > 14 ? 14 : k), 2'h0);
            hw[k] = 1'b1;
            wack(1);
            hw = 16'h0000;
            tick(4);
            wr(8'hC0, 8'h00);
            wr(8'hC1, 8'h00);
            ret();
        end
        $display("test sources done");
        wr(8'hB7, 8'h02);
        wr(8'hB8, 8'h03);
        take = 1'b0;
        wr(8'hC1, 8'h05);
        note(4'h0, 2'h1);
        take = 1'b1;
        wack(1);
        wr(8'hC1, 8'h04);
        wack(0);
        note(4'h1, 2'h3);
        wr(8'hC1, 8'h06);
        wack(1);
        rd(8'hC2);
        chk(23'(sfrRdata), 23'h0A);
        wr(8'hC1, 8'h04);
        ret();
        wack(0);
        note(4'h2, 2'h0);
        ret();
        wack(1);
        wr(8'hC1, 8'h00);
        ret();
        $display("test nesting done");
        wr(8'hB7, 8'h7F);
        wr(8'hB8, 8'h00);
        wr(8'hF7, 8'hFF);
        take = 1'b0;
        wr(8'hC0, timF);
        wr(8'hC1, 8'h3F);
        hw[13] = 1'b1;
        hw[10] = 1'b1;
        tick(1);
        hw[10] = 1'b0;
        for (int i = 0; i < 15; i++)
            note(poll[i], 2'h2);
        take = 1'b1;
        for (int i = 0; i < 15; i++)
        begin
            wack(1);
            s = poll[i];
            if (s < 6 || s == 10)
                misF[s == 10 ? 6 : s] = 1'b0;
            else if (s == 13)
                hw[13] = 1'b0;
            else
                timF = timF & ~(s == 14 ? 8'hC0 : 8'h01 << (s < 10 ? s - 6 : s - 7));
            wr(8'hC0, timF);
            wr(8'hC1, misF);
            ret();
        end
        $display("test polling done");
        test_done();
    end
endmodule
